// file: inc/adc_port_params.svh
// constants of the converter serial port: word sizes, field positions,
// edge thresholds and reset values.
// assumes nothing; included by bare name wherever the numbers are needed.
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH

// ****************************************************************
// word sizes and edge thresholds
// ****************************************************************
`define OUT_WORD_BITS    6'h20
`define OUT_LAST_FALL    6'h1F
`define IN_WORD_BITS     6'h0D
`define CHAN_MIN_FALLS   6'h08
`define CFG_MIN_FALLS    6'h10

// ****************************************************************
// input word fields, counted from the last bit shifted in
// ****************************************************************
`define IN_PRE_HI        12
`define IN_PRE_LO        10
`define IN_CHAN_HI       9
`define IN_CHAN_LO       5
`define IN_EN2_BIT       4
`define IN_CFG_HI        3
`define PRE_ENABLE       3'h5

// ****************************************************************
// reset values and encodings
// ****************************************************************
`define CHAN_RESET       5'h00
`define CFG_RESET        4'h0
`define REJECT_BAD       2'h3
`define CH_COM           3'h4
`define UNDER_CODE       24'h7F_FFFF
`define SUB_ALL_ONES     5'h1F

`endif

// file: inc/adc_port_pkg.sv
// types shared by the converter serial port.
// assumes nothing; uses none of the params header macros.
package adc_port_pkg;

    // channel selection as shifted in
    typedef struct packed {
        logic single_ended_select;
        logic polarity_bit;
        logic mux_upper_sel_b2;
        logic mux_upper_sel_b1;
        logic channel_pair_select;
    } chan_sel_t;

    // converter configuration as shifted in
    typedef struct packed {
        logic temp_sensor_pick;
        logic reject_sel_hi;
        logic reject_sel_lo;
        logic double_rate_sel;
    } conv_cfg_t;

    // port states
    typedef enum logic [1:0] {
        ST_CONVERT,
        ST_SLEEP,
        ST_DATA
    } port_state_t;

endpackage

// file: rtl/adc_serial_result_config_port.sv
// serial result and configuration port of a delta-sigma converter.
// assumes cs_n, sck and sdi come from pins (asynchronous), and that the
// converter core sits on clk and reports conversions with a one-cycle pulse.
// What this block does
// R01: chip select high: sdo released, sck ignored
// R02: outside data state sdo shows conversion-done flag
// R03: sleep after conversion until chip select low in external mode
// R04: new conversion after all 32 bits out
// R05: chip select rise mid-cycle aborts, starts conversion
// R06: sdi sampled on rising sck, chip select low
// R07: 32-bit word, flag, zero, sign, result, sub-bits
// R08: sign high for positive input
// R09: sign and msb flag over and underrange
// R10: out-of-range results clamp one step past full scale
// R11: sdo changes on falling sck edges
// R12: 32nd falling edge drives sdo high
// R13: done flag falls at once, no sck needed
// R14: input word is 13 bits
// R15: reset defaults, then first conversion starts
// R16: preambles 000 and 100 keep everything
// R17: preamble 101 loads five channel bits
// R18: channel bits decode into positive and negative inputs
// R19: update flag zero keeps configuration
// R20: temperature pick, rejection codes, reserved code refused
// R21: rate bit, forced single rate for temperature
// R22: configuration held until next enabled update
// R23: sck level at chip select fall sets clock mode
// R24: aborted cycle applies bits by falling-edge count
// R25: core gets channel and configuration at start
`timescale 1ns/1ps
`default_nettype none

`include "adc_port_params.svh"

module adc_serial_result_config_port
    import adc_port_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // serial pins
    input  wire logic          cs_n_i,
    input  wire logic          sck_i,
    input  wire logic          sdi_i,
    output logic               sdo_o,
    output logic               sdo_oe,
    // converter core, result side
    input  wire logic          core_done,
    input  wire logic          core_sign,
    input  wire logic          core_over,
    input  wire logic          core_under,
    input  wire logic [23:0]   core_code,
    input  wire logic [4:0]    core_sub,
    // converter core, start side
    output logic               conv_start,
    output chan_sel_t          conv_chan,
    output conv_cfg_t          conv_cfg,
    output logic [2:0]         conv_pos_ch,
    output logic [2:0]         conv_neg_ch,
    // status
    output logic               low_power,
    output logic               int_sck_mode
);

    // ****************************************************************
    // state record
    // ****************************************************************

    // pin order in the sync vectors: 2 = cs_n, 1 = sck, 0 = sdi
    typedef struct packed {
        logic [2:0]  sync1;      // first stage, read only by sync2
        logic [2:0]  sync2;      // second stage
        logic [2:0]  sync3;      // third stage
        logic [2:0]  pins;       // accepted pin levels
        logic        started;    // first cycle after reset handled
        port_state_t state;      // port state
        logic        busy;       // conversion in progress
        logic [31:0] out_word;   // output shift register
        logic [12:0] in_word;    // input shift register
        logic [5:0]  rises;      // rising sck edges this cycle
        logic [5:0]  falls;      // falling sck edges this cycle
        chan_sel_t   chan;       // channel in force
        conv_cfg_t   cfg;        // configuration in force
        logic        start;      // conversion start pulse
        logic [2:0]  pos_ch;     // decoded positive input
        logic [2:0]  neg_ch;     // decoded negative input
        logic        sdo;        // sdo level
        logic        oe;         // sdo enable
        logic        int_mode;   // internal clock mode selected
        logic        low_pw;     // sleep with chip select high
    } port_reg_t;

    port_reg_t st_q;             // registered state
    port_reg_t st_d;             // next state

    // ****************************************************************
    // helpers
    // ****************************************************************

    // build the result word from the core outputs
    function automatic logic [31:0] build_word(
        input logic        sign,
        input logic        over,
        input logic        under,
        input logic [23:0] code,
        input logic [4:0]  sub
    );
        logic [31:0] w;
        w = {1'b0, 1'b0, sign, code, sub};                       // see R07, see R08
        if (over)
        begin
            // clamp to full scale plus one step
            w = {1'b0, 1'b0, 1'b1, 24'h80_0000, 5'h00};          // see R09, see R10
        end
        else if (under)
        begin
            // clamp to minus full scale minus one step
            w = {1'b0, 1'b0, 1'b0, `UNDER_CODE, `SUB_ALL_ONES};  // see R09, see R10
        end
        return w;
    endfunction

    // decode the channel bits into input indices, 4 meaning the common return
    function automatic logic [5:0] decode_chan(input chan_sel_t c);
        logic [2:0] lo;
        logic [2:0] hi;
        logic [5:0] r;
        lo = {1'b0, c.channel_pair_select, 1'b0};
        hi = {1'b0, c.channel_pair_select, 1'b1};
        if (!c.single_ended_select)
        begin
            // adjacent pair, polarity bit swaps the pair
            r = c.polarity_bit ? {hi, lo} : {lo, hi};            // see R18
        end
        else
        begin
            // one channel against the common return: 0, 2, 1, 3
            r = {{1'b0, c.channel_pair_select, c.polarity_bit}, `CH_COM}; // see R18
        end
        return r;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************

    // all pin handling, the port sequence and the setting loads
    always_comb
    begin
        logic       cs_fall;
        logic       cs_rise;
        logic       sck_rise;
        logic       sck_fall;
        logic       load_chan;
        logic       load_cfg;
        logic       finish;
        logic [12:0] w;
        chan_sel_t  nc;
        conv_cfg_t  ncfg;
        st_d      = st_q;
        cs_fall   = 1'b0;
        cs_rise   = 1'b0;
        sck_rise  = 1'b0;
        sck_fall  = 1'b0;
        load_chan = 1'b0;
        load_cfg  = 1'b0;
        finish    = 1'b0;
        w         = st_q.in_word;
        nc        = st_q.chan;
        ncfg      = st_q.cfg;
        st_d.start = 1'b0;
        // three-stage pin capture; a change counts when stages two and three agree
        st_d.sync1 = {cs_n_i, sck_i, sdi_i};
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        for (int i = 0; i < 3; i++)
        begin
            if (st_q.sync2[i] == st_q.sync3[i])
            begin
                st_d.pins[i] = st_q.sync3[i];
            end
        end
        // edges of the accepted levels
        cs_fall = st_q.pins[2] & ~st_d.pins[2];
        cs_rise = ~st_q.pins[2] & st_d.pins[2];
        // sck only counts with chip select low and in external mode
        if (!st_d.pins[2] && !st_q.pins[2] && !st_q.int_mode)    // see R01
        begin
            sck_rise = ~st_q.pins[1] & st_d.pins[1];
            sck_fall = st_q.pins[1] & ~st_d.pins[1];
        end
        // first cycle after reset: default settings, strap, first conversion
        if (!st_q.started)
        begin
            st_d.started  = 1'b1;
            st_d.start    = 1'b1;                                // see R15, see R25
            st_d.busy     = 1'b1;
            st_d.int_mode = sck_i;                               // see R23
        end
        // clock mode follows the sck level at each chip select fall
        if (cs_fall)
        begin
            st_d.int_mode = st_d.pins[1];                        // see R23
        end
        // conversion done: result into the shift register
        if (core_done && st_q.busy)
        begin
            st_d.busy     = 1'b0;                                // see R13
            st_d.out_word = build_word(core_sign, core_over, core_under,
                                       core_code, core_sub);
            st_d.state    = ST_SLEEP;                            // see R03
        end
        unique case (st_q.state)
            ST_CONVERT: // nothing to shift; flag shows on sdo
            begin
            end
            ST_SLEEP:
            begin
                // chip select low in external mode leaves sleep for the data state
                if (!st_d.pins[2] && !st_q.int_mode && !cs_fall)
                begin
                    st_d.state   = ST_DATA;                      // see R03
                    st_d.rises   = 6'h00;
                    st_d.falls   = 6'h00;
                    st_d.in_word = 13'h0000;
                end
            end
            ST_DATA:
            begin
                // sdi in on rising edges, first 13 bits only, top bit first so that
                // a cut word still has its fields in place
                if (sck_rise)
                begin
                    if (st_q.rises < `IN_WORD_BITS)
                    begin
                        w[4'(`IN_PRE_HI) - st_q.rises[3:0]] = st_q.pins[0]; // see R06, see R14
                    end
                    st_d.in_word = w;
                    st_d.rises   = st_q.rises + 6'h01;  // at most 32 rises per cycle
                end
                // sdo out on falling edges
                if (sck_fall)
                begin
                    st_d.falls    = st_q.falls + 6'h01;
                    st_d.out_word = {st_q.out_word[30:0], 1'b1}; // see R11
                    if (st_q.falls == `OUT_LAST_FALL)
                    begin
                        finish   = 1'b1;                         // see R04, see R12
                        load_chan = 1'b1;
                        load_cfg  = 1'b1;
                    end
                end
                // chip select rise after the first rising edge aborts
                if (cs_rise && st_q.rises != 6'h00)
                begin
                    finish    = 1'b1;                            // see R05
                    load_chan = (st_q.falls >= `CHAN_MIN_FALLS); // see R24
                    load_cfg  = (st_q.falls >= `CFG_MIN_FALLS);  // see R24
                end
                else if (cs_rise)
                begin
                    // nothing clocked yet: back to sleep
                    st_d.state = ST_SLEEP;
                end
            end
        endcase

        // setting loads; fields sit at fixed places in the word
        if (finish)
        begin
            if (w[`IN_PRE_HI:`IN_PRE_LO] == `PRE_ENABLE)         // see R16, see R17
            begin
                if (load_chan)
                begin
                    nc = chan_sel_t'(w[`IN_CHAN_HI:`IN_CHAN_LO]); // see R17
                end
                if (load_cfg && w[`IN_EN2_BIT])                  // see R19, see R22
                begin
                    // reserved rejection code leaves the old setting alone
                    if (w[2:1] != `REJECT_BAD)                   // see R20
                    begin
                        ncfg = conv_cfg_t'(w[`IN_CFG_HI:0]);     // see R20
                        if (ncfg.temp_sensor_pick)
                        begin
                            ncfg.double_rate_sel = 1'b0;         // see R21
                        end
                    end
                end
            end
            st_d.chan     = nc;
            st_d.cfg      = ncfg;
            st_d.state    = ST_CONVERT;
            st_d.busy     = 1'b1;
            st_d.start    = 1'b1;                                // see R25
            st_d.out_word = 32'hFFFF_FFFF;                       // see R12
        end

        // decoded inputs handed to the core with the start
        {st_d.pos_ch, st_d.neg_ch} = decode_chan(st_d.chan);     // see R18, see R25

        // sdo: released with chip select high
        st_d.oe = ~st_d.pins[2];                                 // see R01
        st_d.low_pw = (st_d.state == ST_SLEEP) & st_d.pins[2];   // see R03
        if (st_d.state == ST_DATA)
        begin
            st_d.sdo = st_d.out_word[31];                        // see R07, see R11
        end
        else
        begin
            st_d.sdo = st_d.busy;                                // see R02, see R13
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************

    // one register for the whole record
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '{
                sync1:    3'h4,
                sync2:    3'h4,
                sync3:    3'h4,
                pins:     3'h4,
                started:  1'b0,
                state:    ST_CONVERT,
                busy:     1'b1,
                out_word: 32'hFFFF_FFFF,
                in_word:  13'h0000,
                rises:    6'h00,
                falls:    6'h00,
                chan:     chan_sel_t'(`CHAN_RESET),              // see R15
                cfg:      conv_cfg_t'(`CFG_RESET),               // see R15
                start:    1'b0,
                pos_ch:   3'h0,
                neg_ch:   3'h1,
                sdo:      1'b1,
                oe:       1'b0,
                low_pw:   1'b0,
                int_mode: 1'b0
            };
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // outputs, straight from the record
    // ****************************************************************

    assign sdo_o        = st_q.sdo;
    assign sdo_oe       = st_q.oe;
    assign conv_start   = st_q.start;
    assign conv_chan    = st_q.chan;
    assign conv_cfg     = st_q.cfg;
    assign conv_pos_ch  = st_q.pos_ch;
    assign conv_neg_ch  = st_q.neg_ch;
    assign low_power    = st_q.low_pw;
    assign int_sck_mode = st_q.int_mode;

endmodule
`default_nettype wire

// file: testbench/adc_port_monitor.sv
// checker of the converter serial port, bound to the top module's ports.
// assumes the shared types package is compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module adc_port_monitor
    import adc_port_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // serial pins
    input wire logic       cs_n_i,
    input wire logic       sdo_o,
    input wire logic       sdo_oe,
    // converter core
    input wire logic       core_done,
    input wire logic       conv_start,
    input wire chan_sel_t  conv_chan,
    input wire conv_cfg_t  conv_cfg,
    input wire logic [2:0] conv_pos_ch,
    input wire logic [2:0] conv_neg_ch,
    // status
    input wire logic       low_power
);
    // ****************************************************************
    // properties, all on the port clock
    // ****************************************************************
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_sdo_released: assert property (cs_n_i [*8] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    chk_sdo_driven: assert property ((!cs_n_i) [*8] |-> sdo_oe)
        else $error("sdo not driven while selected");
    chk_sleep_quiet: assert property (sdo_oe [*2] |-> !low_power)
        else $error("sleep flagged while selected");
    chk_start_single: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    chk_start_flag_high: assert property (conv_start && sdo_oe |-> ##[0:2] (sdo_o || !sdo_oe))
        else $error("sdo low after new conversion");
    chk_done_drops: assert property (core_done && sdo_oe && sdo_o |-> ##[1:2] (!sdo_o || !sdo_oe))
        else $error("done flag late");
    chk_chan_on_start: assert property ($changed(conv_chan) |-> conv_start)
        else $error("channel changed without start");
    chk_cfg_on_start: assert property ($changed(conv_cfg) |-> conv_start)
        else $error("configuration changed without start");
    chk_temp_rate: assert property (conv_cfg.temp_sensor_pick |-> !conv_cfg.double_rate_sel)
        else $error("double rate with temperature");
    chk_reject_code: assert property (conv_cfg.reject_sel_hi |-> !conv_cfg.reject_sel_lo)
        else $error("reserved rejection code used");
    chk_pair_route: assert property (!conv_chan.single_ended_select |->
        conv_pos_ch == {1'b0, conv_chan.channel_pair_select, conv_chan.polarity_bit} &&
        conv_neg_ch == {1'b0, conv_chan.channel_pair_select, !conv_chan.polarity_bit})
        else $error("pair decode wrong");
    chk_single_route: assert property (conv_chan.single_ended_select |-> conv_neg_ch == 3'h4 &&
        conv_pos_ch == {1'b0, conv_chan.channel_pair_select, conv_chan.polarity_bit})
        else $error("single-ended decode wrong");
endmodule

bind adc_serial_result_config_port adc_port_monitor u_adc_port_monitor (
    .clk(clk), .rst_n(rst_n), .cs_n_i(cs_n_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .core_done(core_done), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_cfg(conv_cfg), .conv_pos_ch(conv_pos_ch), .conv_neg_ch(conv_neg_ch),
    .low_power(low_power)
);

`default_nettype wire

// file: testbench/host_model.sv
// serial master standing in for the host controller.
// assumes pins change only at falling clk edges; sck period is 8 clk.
`timescale 1ns/1ps
`default_nettype none

module host_model (
    // bench clock
    input  wire logic clk,
    // device output pin
    input  wire logic sdo_o,
    input  wire logic sdo_oe,
    // pins the host drives
    output var logic  cs_n,
    output var logic  sck,
    output var logic  sdi,
    // level the host reads
    output var logic  sdo_line
);
    logic last_q = 1'b0; // last level driven on the line

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end

    // no pull-up: a released line shows the opposite of its last level
    always @(posedge clk)
        if (sdo_oe)
            last_q <= sdo_o;
    always_comb
        sdo_line = sdo_oe ? sdo_o : ~last_q;

    // wait whole clk cycles, ending on a falling edge
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask

    // set chip select and sck together
    task automatic pins(input logic cs_lvl, input logic sck_lvl);
        @(negedge clk);
        cs_n = cs_lvl;
        sck = sck_lvl;
    endtask

    // nfall sck pulses, word in msb first, bit read at end of high phase
    task automatic xfer(input logic [12:0] din, input int nfall, output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < nfall; i++)
        begin
            sdi = (i < 13) ? din[12 - i] : 1'b0;
            hold(4);
            sck = 1'b1;
            hold(4);
            dout[31 - i] = sdo_line;
            sck = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// file: testbench/test_adc_serial_result_config_port.sv
// bench of the converter serial port: host model, core stand-in, checks.
// assumes package, design, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_adc_serial_result_config_port
    import adc_port_pkg::*;
;
    // one serial cycle: input word, falling edges, result kind, code
    typedef struct packed {
        logic [12:0] din;
        logic [5:0]  nfall;
        logic [1:0]  kind;
        logic [23:0] code;
    } case_t;
    localparam case_t CASES [11] = '{
        '{13'h1433, 6'h20, 2'h1, 24'h12_3456}, '{13'h151D, 6'h20, 2'h2, 24'h00_00AA},
        '{13'h13F0, 6'h20, 2'h3, 24'h00_0055}, '{13'h02B6, 6'h20, 2'h0, 24'hFE_DCBA},
        '{13'h162A, 6'h20, 2'h1, 24'h00_0001}, '{13'h1712, 6'h20, 2'h0, 24'hFF_FFFF},
        '{13'h1734, 6'h07, 2'h1, 24'h00_0000}, '{13'h1532, 6'h08, 2'h1, 24'h00_0000},
        '{13'h1415, 6'h0F, 2'h1, 24'h00_0000}, '{13'h1618, 6'h10, 2'h1, 24'h00_0000},
        '{13'h1735, 6'h20, 2'h0, 24'h55_AA33}};

    logic        clk = 1'b0, rst_n, core_done, core_sign;
    logic        core_over, core_under, conv_start, low_power, int_sck_mode;
    logic        cs_n, sck, sdi, sdo_o, sdo_oe, sdo_line;
    logic [23:0] core_code;
    logic [4:0]  core_sub, exp_chan = 5'h00;
    logic [3:0]  exp_cfg = 4'h0;
    chan_sel_t   conv_chan;
    conv_cfg_t   conv_cfg;
    logic [2:0]  conv_pos_ch, conv_neg_ch;
    int          n_mismatch = 0, num_checks = 0, conv_len = 40, conv_cnt = 0;
    int          n_starts = 0, cycles = 0;

    adc_serial_result_config_port u_adc_serial_result_config_port (
        .clk(clk), .rst_n(rst_n), .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .core_done(core_done), .core_sign(core_sign),
        .core_over(core_over), .core_under(core_under), .core_code(core_code),
        .core_sub(core_sub), .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_cfg(conv_cfg), .conv_pos_ch(conv_pos_ch), .conv_neg_ch(conv_neg_ch),
        .low_power(low_power), .int_sck_mode(int_sck_mode));
    host_model u_host_model (.clk(clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cs_n(cs_n),
        .sck(sck), .sdi(sdi), .sdo_line(sdo_line));

    always #25 clk = ~clk;

    // converter core stand-in: done pulse conv_len cycles after start
    always @(negedge clk)
    begin
        core_done <= (!conv_start && conv_cnt == 1);
        n_starts <= n_starts + int'(conv_start);
        conv_cnt <= conv_start ? conv_len : (conv_cnt > 0 ? conv_cnt - 1 : 0);
    end

    // hang guard, well above the expected run length
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // expected {positive, negative} input for a channel word
    function automatic logic [5:0] route(input logic [4:0] c);
        return c[4] ? {1'b0, c[0], c[3], 3'h4} : {1'b0, c[0], c[3], 1'b0, c[0], ~c[3]};
    endfunction

    // one select / read / release cycle; early selects during conversion
    task automatic run_cycle(input case_t c, input logic early);
        logic [31:0] dout;
        logic [31:0] exp_word;
        int          k;
        core_sign = c.kind[0];
        core_over = (c.kind == 2'h2);
        core_under = (c.kind == 2'h3);
        core_code = c.code;
        core_sub = c.code[4:0];
        exp_word = (c.kind == 2'h2) ? {3'h1, 24'h80_0000, 5'h00} :
                   (c.kind == 2'h3) ? {3'h0, 24'h7F_FFFF, 5'h1F} :
                   {2'h0, c.kind[0], c.code, c.code[4:0]};
        if (!early)
        begin
            u_host_model.hold(conv_len + 20);
            check("sleep", 32'(low_power), 32'h0000_0001);
        end
        u_host_model.pins(1'b0, 1'b0);
        u_host_model.hold(8);
        if (early)
            check("busy flag", 32'(sdo_line), 32'h0000_0001);
        for (k = 0; k < 400 && sdo_line !== 1'b0; k++)
            u_host_model.hold(1);
        check("done flag", 32'(sdo_line), 32'h0000_0000);
        k = n_starts;
        u_host_model.xfer(c.din, int'(c.nfall), dout);
        if (c.nfall == 6'h20)
        begin
            check("result word", dout, exp_word);
            u_host_model.hold(8);
            check("new conversion flag", 32'(sdo_line), 32'h0000_0001);
        end
        u_host_model.pins(1'b1, 1'b0);
        u_host_model.hold(8);
        check("conversion starts", 32'(n_starts - k), 32'h0000_0001);
        if (c.din[12:10] == 3'h5 && c.nfall >= 6'h08)
            exp_chan = c.din[9:5];
        if (c.din[12:10] == 3'h5 && c.din[4] && c.nfall >= 6'h10 && c.din[2:1] != 2'h3)
            exp_cfg = {c.din[3:1], c.din[0] & ~c.din[3]};
        check("channel", 32'(conv_chan), 32'(exp_chan));
        check("config", 32'(conv_cfg), 32'(exp_cfg));
        check("route", 32'({conv_pos_ch, conv_neg_ch}), 32'(route(exp_chan)));
    endtask

    initial
    begin
        rst_n = 1'b0;
        {core_sign, core_over, core_under, core_code, core_sub} = 32'h0000_0000;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        u_host_model.hold(2);
        check("reset config", 32'({conv_chan, conv_cfg}), 32'h0000_0000);
        check("reset route", 32'({conv_pos_ch, conv_neg_ch}), 32'h0000_0001);
        for (int i = 0; i < 10; i++)
            run_cycle(CASES[i], 1'b0);
        conv_len = 200;
        run_cycle(CASES[10], 1'b0);
        run_cycle('{13'h0000, 6'h20, 2'h1, 24'h00_0F00}, 1'b1);
        u_host_model.hold(conv_len + 20);
        u_host_model.pins(1'b1, 1'b1);
        u_host_model.pins(1'b0, 1'b1);
        u_host_model.hold(8);
        check("internal clock mode", 32'(int_sck_mode), 32'h0000_0001);
        u_host_model.pins(1'b1, 1'b0);
        u_host_model.hold(8);
        u_host_model.pins(1'b0, 1'b0);
        u_host_model.hold(8);
        check("external clock mode", 32'(int_sck_mode), 32'h0000_0000);
        u_host_model.pins(1'b1, 1'b0);
        u_host_model.hold(8);
        end_of_test();
    end
endmodule

`default_nettype wire
